// ---- logic/iface_store.sv ----
`timescale 1ns/1ps
module iface_store #(
	parameter int W  = 36,
	parameter int AW = 4
) (
	input  wire logic          core_clk,
	input  wire logic          rstn,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data_reg
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_reg <= '0;
		end else begin
			rd_data_reg <= mem[rd_addr];
		end
	end
endmodule : iface_store

// ---- logic/scanner_byte_path.sv ----
// Summary of operation
// [RULE_01] transmit bytes come from the staged halfword or straight from control store
// [RULE_02] direct transfer picks even or odd byte by start-on-odd and burst position
// [RULE_03] write front-end phase moves one byte of the staged halfword to front-end data output
// [RULE_04] write front-end phase may run with no prior cycle-steal data phase
// [RULE_05] each sent byte carries a control byte with line coding and end of burst
// [RULE_06] transmit underrun blocks any byte to the front end
// [RULE_07] force-10 timer full blocks any transmit byte
// [RULE_08] receive overrun blocks any byte transfer
// [RULE_09] received byte is stacked into the staged halfword when allowed
// [RULE_10] stacking the first byte of a halfword sets the halfword byte pointer on; the second byte clears it
// [RULE_11] started asynchronous timer counts on its time base and detects full
// [RULE_12] asynchronous timer full resets the stored timer value
// [RULE_13] short timer uses the external 480 Hz time base
// [RULE_14] long timer uses the external 100 ms time base
// [RULE_15] burst boundary or end of transmission starts the receive short timer
// [RULE_16] end of transmission stops force-10 timer, clearing value and work bits
// [RULE_17] force-10 full keeps running, or stays stacked with timer enable option
// [RULE_18] force-30 full raises level 2 timeout to the control processor
// [RULE_19] force-0 stops and resets the synchronous receive timer
// [RULE_20] three-address control after end-3 flag forces burst length to three
// [RULE_21] three-address control without end-3 flag leaves burst length alone
// [RULE_22] transmit write phase checks staged parity; bad raises internal error
// [RULE_23] receive stacking checks incoming parity; bad raises internal error
// [RULE_24] each halfword boundary adds one to the two-bit halfword count
// [RULE_25] per-interface transmit and receive entries, one entry per scan slot
`timescale 1ns/1ps
module scanner_byte_path
	import scanner_pkg::*;
#(
	parameter int IFACE_AW = 3
) (
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                tb_short,
	input  wire logic                tb_long,
	output logic                     slot_active,
	output logic      [IFACE_AW-1:0] slot_iface,
	output logic                     slot_rx,
	input  wire logic                cp_data_valid,
	input  wire logic [15:0]         cp_halfword,
	input  wire logic [1:0]          cp_par,
	input  wire logic                wfe_req,
	input  wire logic                direct_req,
	input  wire logic                burst_start,
	input  wire logic                end_of_burst,
	input  wire logic                underrun,
	input  wire logic                overrun,
	input  wire logic                rx_byte_valid,
	input  wire logic [7:0]          incoming_byte_field,
	input  wire logic                rx_par,
	input  wire logic                end_of_transmission,
	input  wire logic                burst_boundary,
	input  wire logic                timer_start,
	input  wire logic                force10_start,
	input  wire logic                force30_start,
	input  wire logic                force0,
	input  wire logic                end3_flag,
	input  wire logic                param_valid,
	input  wire logic                param_three_addr,
	input  wire logic [3:0]          param_burst_len,
	output logic                     fe_valid_reg,
	output logic      [7:0]          front_end_data_field_reg,
	output logic      [7:0]          fe_ctrl_reg,
	output logic                     rx_hw_valid_reg,
	output logic      [15:0]         rx_hw_reg,
	output logic                     l2_timeout_reg,
	output logic                     l2_internal_error_reg,
	output logic                     async_full_reg
);
	localparam int AW = IFACE_AW + 1;
	localparam logic [AW-1:0] LAST_ADDR = {AW{1'b1}};

	typedef enum logic [1:0] {INIT, READ, PROC} scan_state_type;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic parity_bad(input logic [7:0] b,
		input logic p);
		parity_bad = ~(^{b, p});
	endfunction : parity_bad

	// ------------------------------------------------------------
	// registers and bus slave
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_reg;
	logic [7:0]        limit_reg;
	logic [7:0]        err_count_reg;
	scan_state_type    state_reg;
	logic [AW-1:0]     addr_reg;
	logic              wb_hit;

	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg  <= CTRL_RESET[CTRL_W-1:0];
			limit_reg <= LIMIT_RESET;
		end else if (wb_hit & wb_we_i & wb_sel_i[0]) begin
			if (wb_adr_i == CTRL_OFFSET) begin
				ctrl_reg <= wb_dat_i[CTRL_W-1:0];
			end else if (wb_adr_i == LIMIT_OFFSET) begin
				limit_reg <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_hit;
			if (wb_hit & ~wb_we_i) begin
				if (wb_adr_i == CTRL_OFFSET) begin
					wb_dat_o <= {{(32-CTRL_W){1'b0}}, ctrl_reg};
				end else if (wb_adr_i == LIMIT_OFFSET) begin
					wb_dat_o <= {24'h0, limit_reg};
				end else if (wb_adr_i == STATUS_OFFSET) begin
					wb_dat_o <= {16'h0, err_count_reg,
						(state_reg == INIT), {(7-AW){1'b0}}, addr_reg};
				end else begin
					wb_dat_o <= 32'h0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// time base synchronisers and round ticks
	// ------------------------------------------------------------
	logic [2:0] short_sync_reg;
	logic [2:0] long_sync_reg;
	logic       short_seen_reg;
	logic       long_seen_reg;
	logic       round_short_reg;
	logic       round_long_reg;
	logic       short_edge;
	logic       long_edge;
	logic       round_end;

	assign short_edge = short_sync_reg[1] & ~short_sync_reg[2];
	assign long_edge  = long_sync_reg[1] & ~long_sync_reg[2];
	assign round_end  = (state_reg == PROC) && (addr_reg == LAST_ADDR);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			short_sync_reg <= 3'h0;
			long_sync_reg  <= 3'h0;
		end else begin
			short_sync_reg <= {short_sync_reg[1:0], tb_short}; // RULE_13
			long_sync_reg  <= {long_sync_reg[1:0], tb_long}; // RULE_14
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			short_seen_reg  <= 1'b0;
			long_seen_reg   <= 1'b0;
			round_short_reg <= 1'b0;
			round_long_reg  <= 1'b0;
		end else if (round_end) begin
			round_short_reg <= short_seen_reg | short_edge;
			round_long_reg  <= long_seen_reg | long_edge;
			short_seen_reg  <= 1'b0;
			long_seen_reg   <= 1'b0;
		end else begin
			short_seen_reg <= short_seen_reg | short_edge;
			long_seen_reg  <= long_seen_reg | long_edge;
		end
	end

	// ------------------------------------------------------------
	// scan sequencer and interface store
	// ------------------------------------------------------------
	logic [ENTRY_W-1:0] rd_entry;
	logic [ENTRY_W-1:0] wr_entry;
	logic               wr_en;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= INIT;
			addr_reg  <= '0;
		end else begin
			case (state_reg)
				INIT: begin
					addr_reg <= addr_reg + 1'b1;
					if (addr_reg == LAST_ADDR) begin
						state_reg <= READ;
					end
				end
				READ: begin
					if (ctrl_reg[CTRL_SCAN_EN]) begin
						state_reg <= PROC;
					end
				end
				default: begin
					state_reg <= READ;
					addr_reg  <= addr_reg + 1'b1; // RULE_25
				end
			endcase
		end
	end

	assign slot_active = (state_reg == PROC);
	assign slot_iface  = addr_reg[AW-1:1];
	assign slot_rx     = addr_reg[0];
	assign wr_en       = (state_reg == INIT) || (state_reg == PROC);

	iface_store #(.W(ENTRY_W), .AW(AW)) u_store (
		.core_clk    (core_clk),
		.rstn        (rstn),
		.wr_en       (wr_en),
		.wr_addr     (addr_reg),
		.wr_data     ((state_reg == INIT) ? '0 : wr_entry),
		.rd_addr     (addr_reg),
		.rd_data_reg (rd_entry)
	); // RULE_25

	// ------------------------------------------------------------
	// slot processing
	// ------------------------------------------------------------
	logic [15:0] rd_staged, wr_staged, src_hw;
	logic [1:0]  rd_par, wr_par, src_par, rd_hw, wr_hw;
	logic [7:0]  rd_timer, wr_timer, send_byte;
	logic [3:0]  rd_blen, wr_blen;
	logic        rd_ptr, wr_ptr, rd_work, wr_work, rd_full, wr_full;
	logic        rd_end3, wr_end3, tick, timer_at_full, f10_full_now;
	logic        blocked, direct, byte_odd, send, send_par, bad_tx;
	logic        bad_rx, timeout, afull, hw_out;

	assign rd_staged = rd_entry[E_STAGED_LSB +: 16];
	assign rd_par    = rd_entry[E_PAR_LSB +: 2];
	assign rd_ptr    = rd_entry[E_PTR];
	assign rd_timer  = rd_entry[E_TIMER_LSB +: 8];
	assign rd_work   = rd_entry[E_WORK];
	assign rd_full   = rd_entry[E_FULL];
	assign rd_hw     = rd_entry[E_HW_LSB +: 2];
	assign rd_blen   = rd_entry[E_BLEN_LSB +: 4];
	assign rd_end3   = rd_entry[E_END3];
	assign wr_entry  = {wr_end3, wr_blen, wr_hw, wr_full, wr_work,
		wr_timer, wr_ptr, wr_par, wr_staged};
	assign tick = ctrl_reg[CTRL_ASYNC] & ctrl_reg[CTRL_LONG_BASE] ?
		round_long_reg : round_short_reg; // RULE_13 RULE_14
	assign timer_at_full = (rd_timer == limit_reg);

	always_comb begin
		wr_staged = rd_staged;
		wr_par = rd_par;
		wr_ptr = rd_ptr;
		wr_timer = rd_timer;
		wr_work = rd_work;
		wr_full = rd_full;
		wr_hw = rd_hw;
		wr_blen = rd_blen;
		wr_end3 = rd_end3;
		f10_full_now = 1'b0;
		timeout = 1'b0;
		afull = 1'b0;
		send = 1'b0;
		bad_tx = 1'b0;
		bad_rx = 1'b0;
		hw_out = 1'b0;
		direct = direct_req & cp_data_valid;
		src_hw = direct ? cp_halfword : rd_staged; // RULE_01
		src_par = direct ? cp_par : rd_par;
		byte_odd = direct ? (ctrl_reg[CTRL_START_ODD] & burst_start)
			: rd_ptr; // RULE_02
		send_byte = byte_odd ? src_hw[7:0] : src_hw[15:8];
		send_par = byte_odd ? src_par[0] : src_par[1];
		// timers
		if (ctrl_reg[CTRL_ASYNC]) begin
			if (timer_start || (slot_rx &&
				(burst_boundary || end_of_transmission))) begin
				wr_work = 1'b1; // RULE_15
				wr_timer = 8'h00;
			end else if (rd_work && tick) begin
				if (timer_at_full) begin
					wr_timer = 8'h00; // RULE_12
					wr_work = 1'b0;
					afull = 1'b1; // RULE_11
				end else begin
					wr_timer = rd_timer + 8'h01; // RULE_11
				end
			end
		end else if (!slot_rx) begin
			if (end_of_transmission) begin
				wr_timer = 8'h00; // RULE_16
				wr_work = 1'b0;
				wr_full = 1'b0;
			end else if (force10_start) begin
				wr_timer = 8'h00;
				wr_work = 1'b1;
				wr_full = 1'b0;
			end else if (rd_work && !rd_full && tick && timer_at_full) begin
				f10_full_now = 1'b1;
				if (ctrl_reg[CTRL_TIMER_EN]) begin
					wr_full = 1'b1; // RULE_17
				end else begin
					wr_timer = 8'h00; // RULE_17
				end
			end else if (rd_work && !rd_full && tick) begin
				wr_timer = rd_timer + 8'h01;
			end
		end else begin
			if (force0) begin
				wr_timer = 8'h00; // RULE_19
				wr_work = 1'b0;
				wr_full = 1'b0;
			end else if (force30_start) begin
				wr_timer = 8'h00;
				wr_work = 1'b1;
			end else if (rd_work && tick && timer_at_full) begin
				timeout = 1'b1; // RULE_18
				wr_timer = 8'h00;
				wr_work = 1'b0;
			end else if (rd_work && tick) begin
				wr_timer = rd_timer + 8'h01;
			end
		end
		blocked = underrun | f10_full_now | rd_full; // RULE_06 RULE_07
		// data path
		if (!slot_rx) begin
			if (wfe_req && !blocked) begin
				send = 1'b1; // RULE_03 RULE_04
				bad_tx = parity_bad(send_byte, send_par); // RULE_22
				wr_staged = src_hw;
				wr_par = src_par;
				wr_ptr = ~byte_odd;
				if (byte_odd) begin
					wr_hw = rd_hw + 2'h1; // RULE_24
				end
			end else if (!wfe_req && cp_data_valid && !underrun) begin
				wr_staged = cp_halfword;
				wr_par = cp_par;
				wr_ptr = 1'b0;
			end
		end else begin
			if (rx_byte_valid && !overrun) begin // RULE_08
				bad_rx = parity_bad(incoming_byte_field, rx_par); // RULE_23
				if (!rd_ptr) begin
					wr_staged[15:8] = incoming_byte_field; // RULE_09
					wr_par[1] = rx_par;
					wr_ptr = 1'b1; // RULE_10
				end else begin
					wr_staged[7:0] = incoming_byte_field; // RULE_09
					wr_par[0] = rx_par;
					wr_ptr = 1'b0;
					wr_hw = rd_hw + 2'h1; // RULE_24
					hw_out = 1'b1;
				end
			end
			if (param_valid) begin
				if (param_three_addr && rd_end3) begin
					wr_blen = THREE_ADDR_LEN; // RULE_20
				end else if (!param_three_addr) begin
					wr_blen = param_burst_len; // RULE_21
				end
				wr_end3 = 1'b0;
			end else if (end3_flag) begin
				wr_end3 = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic proc;
	assign proc = (state_reg == PROC);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fe_valid_reg <= 1'b0;
			front_end_data_field_reg <= 8'h00;
			fe_ctrl_reg <= 8'h00;
		end else begin
			fe_valid_reg <= proc & send;
			if (proc & send) begin
				front_end_data_field_reg <= send_byte; // RULE_03
				fe_ctrl_reg <= 8'h00;
				fe_ctrl_reg[FE_CTRL_LINE_CODING] <=
					ctrl_reg[CTRL_LINE_CODING]; // RULE_05
				fe_ctrl_reg[FE_CTRL_EOB] <= end_of_burst; // RULE_05
				fe_ctrl_reg[FE_CTRL_ODD] <= byte_odd;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_hw_valid_reg <= 1'b0;
			rx_hw_reg <= 16'h0000;
		end else begin
			rx_hw_valid_reg <= proc & hw_out;
			if (proc & hw_out) begin
				rx_hw_reg <= {rd_staged[15:8], incoming_byte_field};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			l2_timeout_reg <= 1'b0;
			l2_internal_error_reg <= 1'b0;
			async_full_reg <= 1'b0;
			err_count_reg <= 8'h00;
		end else begin
			l2_timeout_reg <= proc & timeout; // RULE_18
			l2_internal_error_reg <= proc & (bad_tx | bad_rx); // RULE_22 RULE_23
			async_full_reg <= proc & afull;
			if (proc & (bad_tx | bad_rx)) begin
				err_count_reg <= err_count_reg + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_tx_slot;
		proc && !slot_rx;
	endsequence

	sequence s_rx_stack;
		proc && slot_rx && rx_byte_valid && !overrun;
	endsequence

	a_underrun_block: assert property (s_tx_slot and underrun |=> !fe_valid_reg) // RULE_06
		else $error("byte sent during underrun");
	a_f10_block: assert property (s_tx_slot and f10_full_now |=> !fe_valid_reg) // RULE_07
		else $error("byte sent at force-10 full");
	a_overrun_block: assert property (proc && slot_rx && overrun |-> wr_ptr == rd_ptr && wr_staged == rd_staged) // RULE_08
		else $error("receive transfer during overrun");
	a_stack_ptr_on: assert property (s_rx_stack and !rd_ptr |-> wr_ptr && wr_staged[15:8] == incoming_byte_field) // RULE_10
		else $error("pointer not set after stacking");
	a_eot_clear: assert property (s_tx_slot and !ctrl_reg[CTRL_ASYNC] && end_of_transmission |-> wr_timer == 8'h00 && !wr_work && !wr_full) // RULE_16
		else $error("force-10 not cleared by end of transmission");
	a_three_addr: assert property (proc && slot_rx && param_valid && param_three_addr && rd_end3 |-> wr_blen == 4'h3) // RULE_20
		else $error("burst length not forced to three");
	a_no_end3: assert property (proc && slot_rx && param_valid && param_three_addr && !rd_end3 |-> wr_blen == rd_blen) // RULE_21
		else $error("burst length changed without end-3");
	a_rx_parity: assert property (s_rx_stack |=> l2_internal_error_reg == $past(parity_bad(incoming_byte_field, rx_par))) // RULE_23
		else $error("receive parity report wrong");
	a_tx_parity: assert property (s_tx_slot and send |=> l2_internal_error_reg == $past(parity_bad(send_byte, send_par)) && fe_valid_reg) // RULE_22
		else $error("transmit parity report wrong");
	a_async_full: assert property (proc && ctrl_reg[CTRL_ASYNC] && !timer_start && !slot_rx && rd_work && tick && timer_at_full |-> wr_timer == 8'h00 ##1 async_full_reg) // RULE_12
		else $error("async full did not reset timer");
	a_f30_timeout: assert property (proc && slot_rx && !ctrl_reg[CTRL_ASYNC] && !force0 && !force30_start && rd_work && tick && timer_at_full |=> l2_timeout_reg) // RULE_18
		else $error("force-30 full without timeout");
	a_hw_count: assert property (s_rx_stack and rd_ptr |-> wr_hw == rd_hw + 2'h1 ##1 rx_hw_valid_reg) // RULE_24
		else $error("halfword count not advanced");
endmodule : scanner_byte_path

// ---- logic/scanner_pkg.sv ----
package scanner_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] LIMIT_OFFSET  = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] LIMIT_RESET   = 8'h3F;
	// control register bits
	localparam int CTRL_SCAN_EN     = 0;
	localparam int CTRL_ASYNC       = 1;
	localparam int CTRL_TIMER_EN    = 2;
	localparam int CTRL_LINE_CODING = 3;
	localparam int CTRL_LONG_BASE   = 4;
	localparam int CTRL_START_ODD   = 5;
	localparam int CTRL_W           = 6;
	// ------------------------------------------------------------
	// interface store entry layout
	// ------------------------------------------------------------
	localparam int E_STAGED_LSB = 0;
	localparam int E_PAR_LSB    = 16;
	localparam int E_PTR        = 18;
	localparam int E_TIMER_LSB  = 19;
	localparam int E_WORK       = 27;
	localparam int E_FULL       = 28;
	localparam int E_HW_LSB     = 29;
	localparam int E_BLEN_LSB   = 31;
	localparam int E_END3       = 35;
	localparam int ENTRY_W      = 36;
	localparam logic [3:0] THREE_ADDR_LEN = 4'h3;
	// ------------------------------------------------------------
	// front-end control byte bits
	// ------------------------------------------------------------
	localparam int FE_CTRL_LINE_CODING = 0;
	localparam int FE_CTRL_EOB         = 1;
	localparam int FE_CTRL_ODD         = 2;
endpackage : scanner_pkg

// ---- verification/scan_partner.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: drives the slot flag inputs only in its own slot; data lines are always driven
// ------------------------------------------------------------
module scan_partner (
	input  wire logic        slot_active,
	input  wire logic [2:0]  slot_iface,
	input  wire logic        slot_rx,
	input  wire logic        en,
	input  wire logic [3:0]  tgt,
	input  wire logic [16:0] fi,
	input  wire logic [30:0] di,
	output logic      [16:0] fo,
	output logic      [30:0] dq
);
	logic go;
	assign go = en && slot_active && ({slot_iface, slot_rx} == tgt);
	assign fo = go ? fi : 17'h00000;
	// released data lines show the inverse of the held value
	assign dq = go ? di : ~di;
endmodule : scan_partner

// ---- verification/tb_scanner_byte_path.sv ----
`timescale 1ns/1ps
module tb_scanner_byte_path;
	import scanner_pkg::*;
	localparam logic [16:0] CPV = 17'h00001, WFE = 17'h00002;
	localparam logic [16:0] DIR = 17'h00004, BS = 17'h00008;
	localparam logic [16:0] EOB = 17'h00010, UND = 17'h00020;
	localparam logic [16:0] OVR = 17'h00040, RXV = 17'h00080;
	localparam logic [16:0] END_OF_TRANSMISSION = 17'h00100, BB = 17'h00200;
	localparam logic [16:0] TS = 17'h00400, F10 = 17'h00800;
	localparam logic [16:0] F30 = 17'h01000, F0 = 17'h02000;
	localparam logic [16:0] PV = 17'h04000, E3 = 17'h08000;
	localparam logic [16:0] TA = 17'h10000;
	logic        core_clk = 1'b0, rstn = 1'b0, en = 1'b0, tb_long;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF, tgt = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic        wb_ack_o, tb_short, slot_active, slot_rx;
	logic [2:0]  slot_iface;
	logic [16:0] fi = 17'h0, fo;
	logic [30:0] di = 31'h0, dq;
	logic        cp_data_valid, wfe_req, direct_req, burst_start;
	logic        end_of_burst, underrun, overrun, rx_byte_valid;
	logic        end_of_transmission, burst_boundary, timer_start;
	logic        force10_start, force30_start, force0, end3_flag;
	logic        param_valid, param_three_addr, rx_par;
	logic [15:0] cp_halfword, rx_hw_reg, hw;
	logic [1:0]  cp_par;
	logic [7:0]  incoming_byte_field, front_end_data_field_reg;
	logic [7:0]  fe_ctrl_reg, fd, fc;
	logic [3:0]  param_burst_len;
	logic        fe_valid_reg, rx_hw_valid_reg, l2_timeout_reg;
	logic        l2_internal_error_reg, async_full_reg;
	int          cyc = 0, error_cnt = 0, checks_done = 0, i;
	int          n_fe = 0, n_hw = 0, n_er = 0, n_to = 0, n_af = 0;
	logic [7:0]  rb [5] = '{8'h12, 8'h34, 8'h99, 8'h56, 8'h78};
	logic [16:0] st [3] = '{TS, BB, END_OF_TRANSMISSION};
	assign {param_three_addr, param_valid, end3_flag, force0} = fo[16:13];
	assign {force30_start, force10_start, timer_start} = fo[12:10];
	assign {burst_boundary, end_of_transmission, rx_byte_valid} = fo[9:7];
	assign {overrun, underrun, end_of_burst, burst_start} = fo[6:3];
	assign {direct_req, wfe_req, cp_data_valid} = fo[2:0];
	assign {param_burst_len, rx_par, incoming_byte_field} = dq[30:18];
	assign {cp_par, cp_halfword} = dq[17:0];
	assign tb_short = cyc[5];
	assign tb_long = cyc[8];
	scanner_byte_path #(.IFACE_AW(3)) DUT (.*);
	scan_partner far (.*);
	initial forever #10 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// output monitor
	// ------------------------------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (fe_valid_reg === 1'b1) begin
			n_fe <= n_fe + 1;
			fd <= front_end_data_field_reg;
			fc <= fe_ctrl_reg;
		end
		if (rx_hw_valid_reg === 1'b1) begin
			n_hw <= n_hw + 1;
			hw <= rx_hw_reg;
		end
		if (l2_internal_error_reg === 1'b1) n_er <= n_er + 1;
		if (l2_timeout_reg === 1'b1) n_to <= n_to + 1;
		if (async_full_reg === 1'b1) n_af <= n_af + 1;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic op(input logic [7:0] b);
		return ~^b;
	endfunction : op
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input int d);
		int k;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o;
		chk({31'h0, wb_ack_o}, 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic ev(input logic [16:0] f, input logic [30:0] d,
			input logic [3:0] e);
		int k;
		@(posedge core_clk);
		fi <= f;
		di <= d;
		tgt <= e;
		en <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(negedge core_clk);
			if (slot_active === 1'b1 && {slot_iface, slot_rx} === e) break;
		end
		@(posedge core_clk);
		en <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : ev
	task automatic wfor(ref int c, input int v);
		int k;
		for (k = 0; k < 1500 && c < v; k++) @(posedge core_clk);
	endtask : wfor
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (30000) @(posedge core_clk);
		error_cnt++;
		wrap_up();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (20) @(posedge core_clk);
		wb(1'b0, LIMIT_OFFSET, 0);
		chk(rd, {24'h0, LIMIT_RESET});
		wb(1'b0, 8'h0C, -1);
		chk(rd, 32'h0);
		wb(1'b1, LIMIT_OFFSET, 2);
		wb(1'b1, CTRL_OFFSET, 9);
		ev(WFE | DIR | CPV | BS, {13'h0, op(8'hA5), op(8'h5A), 16'hA55A}, 4);
		chk(n_fe, 1);
		chk(fd, 8'hA5);
		chk(fc, 8'h01);
		chk(n_er, 0);
		ev(WFE | EOB, 31'h0, 4);
		chk(fd, 8'h5A);
		chk(fc, 8'h07);
		ev(WFE | UND, 31'h0, 4);
		chk(n_fe, 2);
		wb(1'b1, CTRL_OFFSET, 32'h29);
		ev(WFE | DIR | CPV | BS, {13'h0, op(8'hC3), ~op(8'h3C), 16'hC33C}, 4);
		chk(fd, 8'h3C);
		chk(fc, 8'h05);
		chk(n_er, 1);
		for (i = 0; i < 5; i++) begin
			ev(RXV | (i == 2 ? OVR : 17'h0),
				{4'h0, op(rb[i]) ^ (i == 1), rb[i], 18'h0}, 5);
			if (i == 1) chk(hw, 16'h1234);
		end
		chk(n_hw, 2);
		chk(hw, 16'h5678);
		chk(n_er, 2);
		wb(1'b0, STATUS_OFFSET, 0);
		chk({24'h0, rd[15:8]}, 32'h2);
		ev(E3, 31'h0, 5);
		ev(PV | TA, 31'h0, 5);
		ev(PV | TA, 31'h0, 5);
		ev(F30, 31'h0, 5);
		wfor(n_to, 1);
		chk(n_to, 1);
		ev(F30, 31'h0, 5);
		ev(F0, 31'h0, 5);
		repeat (600) @(posedge core_clk);
		chk(n_to, 1);
		wb(1'b1, CTRL_OFFSET, 32'h0D);
		ev(F10, 31'h0, 4);
		repeat (600) @(posedge core_clk);
		ev(WFE, 31'h0, 4);
		chk(n_fe, 3);
		ev(END_OF_TRANSMISSION, 31'h0, 4);
		ev(WFE, 31'h0, 4);
		chk(n_fe, 4);
		chk(fd, 8'hC3);
		wb(1'b1, CTRL_OFFSET, 32'h0B);
		for (i = 0; i < 3; i++) begin
			ev(st[i], 31'h0, 5);
			wfor(n_af, i + 1);
			chk(n_af, i + 1);
		end
		chk(n_to, 1);
		ev(TS, 31'h0, 4);
		wfor(n_af, 4);
		chk(n_af, 4);
		wb(1'b1, CTRL_OFFSET, 32'h1B);
		ev(TS, 31'h0, 5);
		repeat (600) @(posedge core_clk);
		chk(n_af, 4);
		wfor(n_af, 5);
		chk(n_af, 5);
		wrap_up();
	end
endmodule : tb_scanner_byte_path
